// >>> rtl/alcps_dev.sv
// How it works
// - one 8-bit word each way per 8 kHz frame
// - system bit clocks stay within 64k..2.1M bit/s
// - conversion runs only on the core clock
// - sync rise enables driver, starts conversion next
// - each outgoing bit appears on rising bit clock
// - sync low releases and keeps output released
// - transmit sync low one core clock minimum
// - sync pulses eight bits wide, every 125 us
// - first bit taken while sync and clock high
// - sync edges offset from bit clock edges
// - a-law companding with even-bit inversion
// - drive shared line only inside own window
// - analog output updates about 7 us later
// - receive sync high shifts input register
// - receive sync drops before ninth rising edge
// - receive sync low seventeen core clocks minimum
// - polarity, three segment bits, four step bits
module alcps_dev
    import alcps_pkg::*;
(
    input  wire logic              core_clk_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    input  wire logic [LIN_W-1:0]  adc_sample_i,
    output logic                   conv_start_o,
    output logic      [LIN_W-1:0]  dac_o,
    output logic                   dac_update_o,
    alcps_link_if.dev              link
);

    // linear {sign, magnitude} to companded line word
    function automatic logic [WORD_W-1:0] alcps_encode(
        input logic [LIN_W-1:0] lin
    );
        logic [SEG_W-1:0]  seg;
        logic [STEP_W-1:0] stp;
        logic [MAG_W-1:0]  mag;
        mag = lin[MAG_W-1:0];
        seg = '0;
        // highest set bit above the linear region picks the segment
        for (int i = 1; i < (1 << SEG_W); i++) begin
            if (mag[i + STEP_BASE]) begin
                seg = SEG_W'(i);
            end
        end
        // segments 0 and 1 share the same step size
        if (seg == '0) begin
            stp = mag[STEP_W:1];
        end else begin
            stp = STEP_W'(mag >> seg);
        end
        return {lin[MAG_W], seg, stp} ^ EVEN_INV;
    endfunction : alcps_encode

    // companded line word back to linear, mid-step value
    function automatic logic [LIN_W-1:0] alcps_decode(
        input logic [WORD_W-1:0] word
    );
        logic [WORD_W-1:0] w;
        logic [SEG_W-1:0]  seg;
        logic [MAG_W-1:0]  mag;
        w   = word ^ EVEN_INV;
        seg = w[SIGN_BIT-1:SEG_LSB];
        if (seg == '0) begin
            mag = MAG_W'({w[STEP_W-1:0], 1'b1});
        end else begin
            mag = MAG_W'({1'b1, w[STEP_W-1:0], 1'b1}) << (seg - 1'b1);
        end
        return {w[SIGN_BIT], mag};
    endfunction : alcps_decode

    // ---------------- core domain ----------------
    logic [1:0]         txs_sync;   // transmit sync synchroniser
    logic               txs_d;      // delayed copy for edge detect
    logic [1:0]         rxs_sync;   // receive sync synchroniser
    logic               rxs_d;      // delayed copy for edge detect
    alcps_tx_st_t       tx_st;      // conversion state
    alcps_tx_st_t       next_tx_st;
    alcps_rx_st_t       rx_st;      // analog update state
    alcps_rx_st_t       next_rx_st;
    logic [LIN_W-1:0]   sample_q;   // held analog sample
    logic [WORD_W-1:0]  tx_word;    // last converted word
    logic [WORD_W-1:0]  rx_hold;    // word taken after receive sync
    logic [7:0]         sao_cnt;    // analog output delay counter

    // ---------------- link domains ----------------
    logic [1:0]         tx_rst_s;   // reset carried into tx domain
    logic [1:0]         rx_rst_s;   // reset carried into rx domain
    logic [WORD_W-1:0]  tx_shift;   // outgoing bits still to send
    logic [3:0]         tx_cnt;     // bits sent in this window
    logic               tx_bit;     // output driver value
    logic               tx_oe_n;    // output enable, low drives
    logic [WORD_W-1:0]  rx_shift;   // incoming bits

    // edges seen only after the second synchroniser stage
    wire tx_rise = txs_sync[1] & ~txs_d;
    wire rx_fall = ~rxs_sync[1] & rxs_d;
    wire tx_fall = ~txs_sync[1] & txs_d;
    wire sao_done = sao_cnt == SAO_LAST;
    wire tx_first = tx_cnt == '0;
    wire tx_full  = tx_cnt == TX_BITS;

    // sync pins are foreign to the core clock: two stages first
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            txs_sync <= '0;
            txs_d    <= 1'b0;
            rxs_sync <= '0;
            rxs_d    <= 1'b0;
        end else if (ce_i) begin
            txs_sync <= {txs_sync[0], link.tx_frame_sync};
            txs_d    <= txs_sync[1];
            rxs_sync <= {rxs_sync[0], link.rx_frame_sync};
            rxs_d    <= rxs_sync[1];
        end
    end

    // next state for the conversion sequencer
    always_comb begin
        next_tx_st = tx_st;
        case (tx_st)
            TX_IDLE: begin
                if (tx_rise) begin
                    next_tx_st = TX_CONV;
                end
            end
            TX_CONV: next_tx_st = TX_IDLE;
            default: next_tx_st = TX_IDLE;
        endcase
    end

    // next state for the analog output sequencer
    always_comb begin
        next_rx_st = rx_st;
        case (rx_st)
            RX_IDLE: begin
                if (rx_fall) begin
                    next_rx_st = RX_WAIT;
                end
            end
            RX_WAIT: begin
                if (sao_done) begin
                    next_rx_st = RX_IDLE;
                end
            end
            default: next_rx_st = RX_IDLE;
        endcase
    end

    // a/d path: sample at the sync rise, encode at the sync fall;
    // the word sent in a window is the one converted a frame before
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            tx_st        <= TX_IDLE;
            sample_q     <= LIN_ZERO;
            tx_word      <= IDLE_WORD;
            conv_start_o <= 1'b0;
        end else if (ce_i) begin
            tx_st        <= next_tx_st;
            conv_start_o <= (tx_st == TX_IDLE) & tx_rise;
            if ((tx_st == TX_IDLE) & tx_rise) begin
                sample_q <= adc_sample_i;
            end
            if (tx_fall) begin
                tx_word <= alcps_encode(sample_q);
            end
        end
    end

    // d/a path: take the word once the sync has fallen, then wait
    // out the output delay before the analog value changes
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rx_st        <= RX_IDLE;
            rx_hold      <= IDLE_WORD;
            sao_cnt      <= '0;
            dac_o        <= LIN_ZERO;
            dac_update_o <= 1'b0;
        end else if (ce_i) begin
            rx_st        <= next_rx_st;
            dac_update_o <= (rx_st == RX_WAIT) & sao_done;
            if ((rx_st == RX_IDLE) & rx_fall) begin
                // shift register is quiet while the sync stays low
                rx_hold <= rx_shift;
                sao_cnt <= '0;
            end else if (rx_st == RX_WAIT) begin
                sao_cnt <= sao_cnt + 8'h01;
            end
            if ((rx_st == RX_WAIT) & sao_done) begin
                dac_o <= alcps_decode(rx_hold);
            end
        end
    end

    // reset sets at once: the bit clock stands still in reset
    always_ff @(posedge link.tx_bit_clock or posedge rst_i) begin
        if (rst_i) tx_rst_s <= '1;
        else tx_rst_s <= {tx_rst_s[0], 1'b0};
    end

    always_ff @(posedge link.rx_bit_clock or posedge rst_i) begin
        if (rst_i) rx_rst_s <= '1;
        else rx_rst_s <= {rx_rst_s[0], 1'b0};
    end

    // transmit window: the sync belongs to this clock, so it is used
    // directly; tx_word is quiet here since the core updates it only
    // a few core cycles after the window has closed
    always_ff @(posedge link.tx_bit_clock) begin
        if (tx_rst_s[1]) begin
            tx_shift <= IDLE_WORD;
            tx_cnt   <= '0;
            tx_bit   <= 1'b1;
            tx_oe_n  <= 1'b1;
        end else if (link.tx_frame_sync) begin
            tx_oe_n <= 1'b0;
            if (tx_first) begin
                tx_bit   <= tx_word[WORD_MSB];
                tx_shift <= {tx_word[WORD_MSB-1:0], 1'b0};
            end else begin
                tx_bit   <= tx_shift[WORD_MSB];
                tx_shift <= {tx_shift[WORD_MSB-1:0], 1'b0};
            end
            // a sync held too long repeats no bits past the word
            if (!tx_full) begin
                tx_cnt <= tx_cnt + 4'h1;
            end
        end else begin
            tx_oe_n <= 1'b1;
            tx_cnt  <= '0;
        end
    end

    // receive window: shift in on every rising clock with sync high;
    // the system stops the sync after eight bits
    always_ff @(posedge link.rx_bit_clock) begin
        if (rx_rst_s[1]) begin
            rx_shift <= IDLE_WORD;
        end else if (link.rx_frame_sync) begin
            rx_shift <= {rx_shift[WORD_MSB-1:0], link.rx_data};
        end
    end

    // release follows the next rising clock after the sync falls
    assign link.tx_data      = tx_bit;
    assign link.tx_data_oe_n = tx_oe_n;

endmodule : alcps_dev

// >>> rtl/alcps_pkg.sv
// shared constants and types for the pcm port
package alcps_pkg;

    // word layout: polarity, segment, step
    localparam int          WORD_W    = 8;
    localparam int          SEG_W     = 3;
    localparam int          STEP_W    = 4;
    localparam int          LIN_W     = 13;  // sign plus 12-bit magnitude
    localparam int          MAG_W     = 12;
    localparam int          WORD_MSB  = WORD_W - 1;
    localparam int          SEG_LSB   = STEP_W;
    localparam int          SIGN_BIT  = SEG_LSB + SEG_W;
    localparam int          STEP_BASE = STEP_W;  // magnitude bit of seg 0
    localparam logic [7:0]  EVEN_INV  = 8'h55;   // even-order bit flip
    localparam logic [7:0]  IDLE_WORD = 8'hD5;   // positive zero, on line
    localparam logic [12:0] LIN_ZERO  = 13'h0000;

    // conversion clock and derived counts
    localparam int CORE_NS  = 40;
    localparam int FRAME_NS = 125000;
    localparam int SAO_NS   = 7000;
    localparam int FRAME_CYC = FRAME_NS / CORE_NS;
    localparam logic [7:0] SAO_LAST = 8'(SAO_NS / CORE_NS - 1);

    // host bit clock: 25 core cycles per bit gives 1 Mb/s
    localparam int BIT_CYC = 25;
    localparam logic [4:0] PH_LAST  = 5'(BIT_CYC - 1);
    localparam logic [4:0] PH_FALL  = 5'(BIT_CYC / 2);
    localparam logic [4:0] PH_CHG   = 5'(BIT_CYC / 2 + 1);
    localparam logic [6:0] BIT_LAST = 7'(FRAME_CYC / BIT_CYC - 1);
    localparam logic [6:0] SYNC_LAST = 7'(WORD_W - 1);
    localparam logic [3:0] TX_BITS  = 4'(WORD_W);

    // buffering
    localparam int FIFO_DEPTH = 16;

    // device core state machines
    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_CONV = 2'b10
    } alcps_tx_st_t;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b01,
        RX_WAIT = 2'b10
    } alcps_rx_st_t;

endpackage : alcps_pkg

// >>> rtl/alcps_link_if.sv
// pcm link between the line-side system and the codec port
interface alcps_link_if;
    logic tx_bit_clock;   // host-made transmit bit clock
    logic tx_frame_sync;  // transmit frame sync
    logic rx_bit_clock;   // host-made receive bit clock
    logic rx_frame_sync;  // receive frame sync
    logic rx_data;        // serial word into the codec
    logic tx_data;        // codec output driver value
    logic tx_data_oe_n;   // codec output enable, low drives
    logic tx_line;        // resolved shared transmit line

    // released line floats high through the pull-up
    assign tx_line = tx_data_oe_n ? 1'b1 : tx_data;

    modport dev (
        input  tx_bit_clock, tx_frame_sync, rx_bit_clock, rx_frame_sync,
        input  rx_data,
        output tx_data, tx_data_oe_n
    );
    modport host (
        output tx_bit_clock, tx_frame_sync, rx_bit_clock, rx_frame_sync,
        output rx_data,
        input  tx_line
    );
endinterface : alcps_link_if

// >>> rtl/alcps_host.sv
// word buffer with registered ready so the source sees a flop
module alcps_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input  wire logic         core_clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output logic              in_ready_o,
    output logic              out_valid_o,
    output logic      [W-1:0] out_data_o,
    input  wire logic         out_ready_i
);
    localparam int AW = $clog2(D);

    logic [W-1:0]  mem [D];   // storage
    logic [AW-1:0] wr_ptr;    // write index
    logic [AW-1:0] rd_ptr;    // read index
    logic [AW:0]   cnt;       // words held
    logic [AW:0]   next_cnt;

    wire push = in_valid_i & in_ready_o;
    wire pop  = out_ready_i & out_valid_o;

    // count changes by push minus pop
    always_comb begin
        next_cnt = cnt;
        if (push & ~pop) begin
            next_cnt = cnt + 1'b1;
        end else if (pop & ~push) begin
            next_cnt = cnt - 1'b1;
        end
    end

    // pointers wrap with the power-of-two depth
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            wr_ptr      <= '0;
            rd_ptr      <= '0;
            cnt         <= '0;
            in_ready_o  <= 1'b1;
            out_valid_o <= 1'b0;
        end else if (ce_i) begin
            if (push) begin
                mem[wr_ptr] <= in_data_i;
                wr_ptr      <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            cnt         <= next_cnt;
            in_ready_o  <= next_cnt != (AW+1)'(D);
            out_valid_o <= next_cnt != '0;
        end
    end

    assign out_data_o = mem[rd_ptr];

endmodule : alcps_fifo

// line-side system: makes bit clocks and syncs, sends and takes words
module alcps_host
    import alcps_pkg::*;
(
    input  wire logic              core_clk_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    input  wire logic              tx_valid_i,
    input  wire logic [WORD_W-1:0] tx_word_i,
    output logic                   tx_ready_o,
    output logic      [WORD_W-1:0] rx_word_o,
    output logic                   rx_valid_o,
    alcps_link_if.host             link
);
    logic [4:0]        phase;    // core cycle within bit
    logic [6:0]        bit_idx;  // bit slot within frame
    logic              bclk;     // bit clock flop
    logic              sync_q;   // both frame syncs
    logic              data_q;   // serial data to codec
    logic [WORD_W-1:0] sh;       // outgoing bits
    logic [WORD_W-1:0] cap;      // incoming bits
    logic [1:0]        line_s;   // tx line synchroniser
    logic              f_valid;
    logic [WORD_W-1:0] f_data;

    // changes land two core cycles after the falling clock edge
    wire at_chg    = phase == PH_CHG;
    wire ph_end    = phase == PH_LAST;
    wire frm_end   = bit_idx == BIT_LAST;
    wire in_win    = bit_idx <= SYNC_LAST;
    wire load      = at_chg & frm_end;
    wire [WORD_W-1:0] next_word = f_valid ? f_data : IDLE_WORD;
    wire [WORD_W-1:0] next_cap  = {cap[WORD_MSB-1:0], line_s[1]};

    alcps_fifo #(.W(WORD_W), .D(FIFO_DEPTH)) u_fifo (
        .core_clk_i  (core_clk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .in_valid_i  (tx_valid_i),
        .in_data_i   (tx_word_i),
        .in_ready_o  (tx_ready_o),
        .out_valid_o (f_valid),
        .out_data_o  (f_data),
        .out_ready_i (load)
    );

    // bit clock divider and 125-slot frame counter
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            phase   <= '0;
            bit_idx <= BIT_LAST;
            bclk    <= 1'b0;
        end else if (ce_i) begin
            phase <= ph_end ? '0 : phase + 5'h01;
            if (ph_end) begin
                bit_idx <= frm_end ? '0 : bit_idx + 7'h01;
            end
            if (ph_end) begin
                bclk <= 1'b1;
            end else if (phase == PH_FALL - 5'h01) begin
                bclk <= 1'b0;
            end
        end
    end

    // sync rises before slot 0, falls after slot 7; data msb first
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sync_q     <= 1'b0;
            data_q     <= 1'b1;
            sh         <= IDLE_WORD;
            cap        <= '0;
            line_s     <= 2'b11;
            rx_word_o  <= IDLE_WORD;
            rx_valid_o <= 1'b0;
        end else if (ce_i) begin
            line_s     <= {line_s[0], link.tx_line};
            rx_valid_o <= 1'b0;
            if (at_chg) begin
                sync_q <= frm_end | (bit_idx < SYNC_LAST);
            end
            if (load) begin
                data_q <= next_word[WORD_MSB];
                sh     <= {next_word[WORD_MSB-1:0], 1'b0};
            end else if (at_chg & in_win) begin
                data_q <= sh[WORD_MSB];
                sh     <= {sh[WORD_MSB-1:0], 1'b0};
            end
            if (at_chg & in_win) begin
                cap <= next_cap;
                if (bit_idx == SYNC_LAST) begin
                    rx_word_o  <= next_cap;
                    rx_valid_o <= 1'b1;
                end
            end
        end
    end

    assign link.tx_bit_clock  = bclk;
    assign link.rx_bit_clock  = bclk;
    assign link.tx_frame_sync = sync_q;
    assign link.rx_frame_sync = sync_q;
    assign link.rx_data       = data_q;

endmodule : alcps_host

// >>> dv/alcps_link_checker.sv
// watches the pcm link between the two ends
module alcps_link_checker (
    input  wire logic core_clk_i,
    input  wire logic rst_i,
    input  wire logic tx_bit_clock,
    input  wire logic tx_frame_sync,
    input  wire logic rx_bit_clock,
    input  wire logic rx_frame_sync,
    input  wire logic rx_data,
    input  wire logic tx_data,
    input  wire logic tx_data_oe_n,
    input  wire logic tx_line
);
    logic [6:0]  arm_cnt;  // core cycles since reset release
    logic        armed;    // link side has had bit clocks to reset itself
    logic        sync_q;   // last sampled transmit sync
    logic        seen;     // one sync rise already seen
    logic [11:0] gap;      // core cycles since the last sync rise
    logic        rise;     // transmit sync rising

    // bit clock stands still in reset, so link flops settle only later
    assign armed = (arm_cnt == 7'h64);
    assign rise  = tx_frame_sync & ~sync_q;

    // arm counter, stops once armed
    always_ff @(posedge core_clk_i) begin
        if (rst_i) arm_cnt <= 7'h00;
        else if (!armed) arm_cnt <= arm_cnt + 7'h01;
    end

    // frame spacing measured in core cycles
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sync_q <= 1'b0;
            seen   <= 1'b0;
            gap    <= 12'h000;
        end else begin
            sync_q <= tx_frame_sync;
            seen   <= seen | rise;
            gap    <= rise ? 12'h001 : gap + 12'h001;
        end
    end

    tx_drive_on_a: assert property (
        @(posedge tx_bit_clock) disable iff (rst_i || !armed)
        tx_frame_sync |=> !tx_data_oe_n)
        else $error("output not driven inside sync window");
    tx_release_a: assert property (
        @(posedge tx_bit_clock) disable iff (rst_i || !armed)
        !tx_frame_sync |=> tx_data_oe_n && tx_line)
        else $error("output not released outside sync window");
    tx_bit_hold_a: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (!tx_data_oe_n && !$rose(tx_bit_clock)) |-> $stable(tx_data))
        else $error("output bit changed away from rising bit clock");
    tx_sync_width_a: assert property (
        @(posedge tx_bit_clock) disable iff (rst_i || !armed)
        $rose(tx_frame_sync) |-> tx_frame_sync[*8] ##1 !tx_frame_sync)
        else $error("transmit sync not eight bits wide");
    frame_period_a: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (rise && seen) |-> gap == 12'hC35)
        else $error("sync period not one frame");
    rx_sync_width_a: assert property (
        @(posedge rx_bit_clock) disable iff (rst_i || !armed)
        $rose(rx_frame_sync) |-> ##8 !rx_frame_sync)
        else $error("receive sync still high at ninth edge");
    rx_sync_gap_a: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        $fell(rx_frame_sync) |->
            !rx_frame_sync[*8] ##1 !rx_frame_sync[*8] ##1 !rx_frame_sync)
        else $error("receive sync low for too few core cycles");
    sync_offset_a: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        $changed(tx_frame_sync) |-> !tx_bit_clock && !$past(tx_bit_clock))
        else $error("sync edge not clear of bit clock edges");
    rx_data_hold_a: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (rx_bit_clock && $past(rx_bit_clock)) |-> $stable(rx_data))
        else $error("receive data moved while bit clock high");
endmodule : alcps_link_checker

// >>> dv/alaw_codec_pcm_serial_port_test.sv
// both ends joined on one link, user sides driven and judged here
module alaw_codec_pcm_serial_port_test
    import alcps_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic              core_clk_i = 1'b0;  // 25 MHz core clock
    logic              rst_i      = 1'b1;  // synchronous reset
    logic              ce_i       = 1'b1;  // both ends always enabled
    logic [LIN_W-1:0]  adc_sample = LIN_ZERO;
    logic              tx_valid   = 1'b0;
    logic [WORD_W-1:0] tx_word    = 8'h00;
    logic              conv_start;
    logic [LIN_W-1:0]  dac;
    logic              dac_update;
    logic              tx_ready;
    logic [WORD_W-1:0] rx_word;
    logic              rx_valid;
    logic [7:0]        tx_sh;              // word seen on the shared line
    logic [7:0]        rx_sh;              // word seen on the input line
    int                tx_n;               // bits seen per window
    int                rx_n;
    int                n_conv   = 0;
    int                n_fail   = 0;
    int                compares = 0;

    always #20 core_clk_i = ~core_clk_i;

    alcps_link_if alcps_link_if_inst ();

    alcps_dev alcps_dev_inst (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .adc_sample_i(adc_sample), .conv_start_o(conv_start),
        .dac_o(dac), .dac_update_o(dac_update),
        .link(alcps_link_if_inst.dev));

    alcps_host alcps_host_inst (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .tx_valid_i(tx_valid), .tx_word_i(tx_word), .tx_ready_o(tx_ready),
        .rx_word_o(rx_word), .rx_valid_o(rx_valid),
        .link(alcps_link_if_inst.host));

    alcps_link_checker alcps_link_checker_inst (
        .core_clk_i(core_clk_i), .rst_i(rst_i),
        .tx_bit_clock(alcps_link_if_inst.tx_bit_clock),
        .tx_frame_sync(alcps_link_if_inst.tx_frame_sync),
        .rx_bit_clock(alcps_link_if_inst.rx_bit_clock),
        .rx_frame_sync(alcps_link_if_inst.rx_frame_sync),
        .rx_data(alcps_link_if_inst.rx_data),
        .tx_data(alcps_link_if_inst.tx_data),
        .tx_data_oe_n(alcps_link_if_inst.tx_data_oe_n),
        .tx_line(alcps_link_if_inst.tx_line));

    // wire watchers, counts restart at each window
    always @(posedge alcps_link_if_inst.tx_frame_sync) begin
        tx_n = 0;
        rx_n = 0;
    end
    // bit is settled mid-period, so take it on the falling clock
    always @(negedge alcps_link_if_inst.tx_bit_clock) begin
        if (alcps_link_if_inst.tx_data_oe_n === 1'b0) begin
            tx_sh = {tx_sh[6:0], alcps_link_if_inst.tx_line};
            tx_n++;
        end
    end
    always @(posedge alcps_link_if_inst.rx_bit_clock) begin
        if (alcps_link_if_inst.rx_frame_sync === 1'b1) begin
            rx_sh = {rx_sh[6:0], alcps_link_if_inst.rx_data};
            rx_n++;
        end
    end
    always @(negedge core_clk_i) begin
        if (conv_start === 1'b1) n_conv++;
    end

    // expected line word from a sign-magnitude sample
    function automatic logic [7:0] enc(logic [12:0] s);
        int       seg;
        logic [3:0] step;
        seg = 0;
        for (int b = 5; b < 12; b++) begin
            if (s[b]) seg = b - 4;
        end
        step = (seg == 0) ? s[4:1] : 4'(s[11:0] >> seg);
        return {s[12], 3'(seg), step} ^ EVEN_INV;
    endfunction : enc

    // expected mid-step value of a line word
    function automatic logic [12:0] dec(logic [7:0] w);
        logic [7:0]  v;
        logic [11:0] m;
        v = w ^ EVEN_INV;
        m = {6'h00, 1'b1, v[3:0], 1'b1} << (v[6:4] - 3'h1);
        if (v[6:4] == 3'h0) m = {7'h00, v[3:0], 1'b1};
        return {v[7], m};
    endfunction : dec

    // samples walk through every segment, odd segments with the sign bit set
    function automatic logic [12:0] samp_of(int i);
        return {1'(i % 2), 12'(12'h013 << (i % 8))};
    endfunction : samp_of

    function automatic logic [7:0] word_of(int i);
        return 8'(8'h3C + 8'h1D * i);
    endfunction : word_of

    task automatic chk(string what, logic [12:0] exp, logic [12:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic print_verdict();
        if (n_fail == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    // one window ends when the host hands its word up
    task automatic wait_rx();
        int k;
        k = 0;
        @(negedge core_clk_i);
        while (rx_valid !== 1'b1 && k < 4000) begin
            @(negedge core_clk_i);
            k++;
        end
        chk("rx_valid_o", 13'h0001, {12'h000, rx_valid});
    endtask : wait_rx

    task automatic t_reset();
        chk("tx_ready_o", 13'h0001, {12'h000, tx_ready});
        chk("rx_valid_o", 13'h0000, {12'h000, rx_valid});
        chk("rx_word_o", {5'h00, IDLE_WORD}, {5'h00, rx_word});
        chk("dac_o", LIN_ZERO, dac);
        chk("dac_update_o", 13'h0000, {12'h000, dac_update});
    endtask : t_reset

    // fill right after a window, then keep pushing for three cycles while full
    task automatic t_fill();
        wait_rx();
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            chk("tx_ready_o", 13'h0001, {12'h000, tx_ready});
            tx_valid = 1'b1;
            tx_word  = word_of(i);
            @(negedge core_clk_i);
        end
        tx_word = 8'hAA;
        repeat (3) @(negedge core_clk_i);
        tx_valid = 1'b0;
        chk("tx_ready_o", 13'h0000, {12'h000, tx_ready});
    endtask : t_fill

    // drain with a new sample each frame, two frames of lag on the way back
    task automatic t_stream();
        int         lat;
        int         conv0;
        logic [7:0] exp_w;
        logic [7:0] exp_t;
        conv0 = n_conv;
        for (int i = 0; i < 18; i++) begin
            wait_rx();
            exp_w = (i < FIFO_DEPTH) ? word_of(i) : IDLE_WORD;
            exp_t = enc((i >= 2) ? samp_of(i - 2) : LIN_ZERO);
            chk("rx_data bits", 13'h0008, 13'(rx_n));
            chk("rx_data word", {5'h00, exp_w}, {5'h00, rx_sh});
            chk("tx_line bits", 13'h0008, 13'(tx_n));
            chk("tx_line word", {5'h00, exp_t}, {5'h00, tx_sh});
            chk("rx_word_o", {5'h00, exp_t}, {5'h00, rx_word});
            if (i == 0) chk("tx_ready_o", 13'h0001, {12'h000, tx_ready});
            adc_sample = samp_of(i);
            lat = 0;
            while (dac_update !== 1'b1 && lat < 300) begin
                @(negedge core_clk_i);
                lat++;
            end
            chk("dac_o", dec(exp_w), dac);
            chk("tx_data_oe_n", 13'h0001,
                13'(alcps_link_if_inst.tx_data_oe_n));
            compares++;
            if (lat < 173 || lat > 179) begin
                n_fail++;
                $display("MISMATCH dac delay expected 173..179 seen %0d", lat);
            end
        end
        chk("conv_start_o", 13'h0012, 13'(n_conv - conv0));
    endtask : t_stream

    // main sequence; reset held for six core cycles
    initial begin
        repeat (6) @(negedge core_clk_i);
        t_reset();
        rst_i = 1'b0;
        t_fill();
        t_stream();
        print_verdict();
    end

    // watchdog: the run needs about twenty frames
    initial begin
        repeat (90000) @(posedge core_clk_i);
        n_fail++;
        print_verdict();
    end
endmodule : alaw_codec_pcm_serial_port_test
